// [design/wwt_top.sv]
// Windowed watchdog timer with register bank, kick sequence and reset request
`timescale 1ns/1ps
module wwt_top
  import wwt_pkg::*;
(
  // Clock and reset
  input  wire logic            ref_clk_i,
  input  wire logic            rst_n_i,
  // Low-power watchdog clock, sampled as a level
  input  wire logic            count_clk_i,
  // APB register bus
  input  wire wwt_apb_req_type apb_i,
  output logic [31:0]          prdata_o,
  output logic                 pready_o,
  output logic                 pslverr_o,
  // System outputs
  output logic                 warn_irq_o,
  output logic                 chip_reset_o,
  output logic                 osc_lock_o
);

  // ==========================================================
  // State
  wwt_state_type st_r;
  wwt_state_type st_nxt;
  logic          cc_rise;
  logic          acc;
  logic          kerr;
  logic          feed;
  logic          evt;
  logic          wm;
  logic [31:0]   wd;

  function automatic logic warn_match(input logic [23:0] c, input logic [9:0] w);
    warn_match = (c[23:WARN_BITS] == 14'h0000) && (c[WARN_BITS-1:0] <= w);
  endfunction

  assign wm = warn_match(st_r.cnt, st_r.warn);
  assign wd = apb_i.pwdata;

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt  = st_r;
    cc_rise = 1'b0;
    kerr    = 1'b0;
    feed    = 1'b0;
    evt     = 1'b0;
    acc     = apb_i.psel && apb_i.penable && st_r.pready;

    // Three stages; a level counts once stages two and three agree
    st_nxt.cc_s1 = count_clk_i;
    st_nxt.cc_s2 = st_r.cc_s1;
    st_nxt.cc_s3 = st_r.cc_s2;
    if ((st_r.cc_s2 == st_r.cc_s3) && (st_r.cc_s3 != st_r.cc_lvl)) begin
      st_nxt.cc_lvl = st_r.cc_s3;
      cc_rise       = st_r.cc_s3;
    end

    // Zero-wait APB: data and ready prepared in setup phase
    st_nxt.pready  = apb_i.psel && !apb_i.penable;
    st_nxt.pslverr = 1'b0;
    if (apb_i.psel && !apb_i.penable) begin
      st_nxt.prdata = 32'h0000_0000;
      if (apb_i.paddr == MODE_CONTROL_OFS) begin
        st_nxt.prdata[RUN_ENABLE_BIT]   = st_r.en_sw;
        st_nxt.prdata[RESET_ENABLE_BIT] = st_r.rst_sw;
        st_nxt.prdata[TIMEOUT_FLAG_BIT] = st_r.tof;
        st_nxt.prdata[WARNING_FLAG_BIT] = st_r.wflag;
        st_nxt.prdata[KICK_PROTECT_BIT] = st_r.prot_sw;
        st_nxt.prdata[OSC_LOCK_BIT]     = st_r.lock;
      end else if (apb_i.paddr == RELOAD_CONSTANT_OFS) begin
        st_nxt.prdata[23:0] = st_r.reload;
      end else if (apb_i.paddr == KICK_SEQUENCE_OFS) begin
        st_nxt.prdata = 32'h0000_0000;
      end else if (apb_i.paddr == COUNTER_READBACK_OFS) begin
        st_nxt.prdata[23:0] = st_r.rb;
      end else if (apb_i.paddr == WARNING_COMPARE_OFS) begin
        st_nxt.prdata[9:0] = st_r.warn;
      end else if (apb_i.paddr == EARLY_KICK_LIMIT_OFS) begin
        st_nxt.prdata[23:0] = st_r.win;
      end else begin
        st_nxt.pslverr = 1'b1;
      end
    end

    // ==========================================================
    // Bus access phase
    if (acc) begin
      if (st_r.armed) begin
        st_nxt.armed = 1'b0;
        if (!(apb_i.pwrite && (apb_i.paddr == KICK_SEQUENCE_OFS) && (wd[7:0] == KICK_SECOND))) begin
          kerr = st_r.running;
        end
      end
      if (apb_i.pwrite) begin
        if (apb_i.paddr == MODE_CONTROL_OFS) begin
          // Sticky set-only bits
          st_nxt.en_sw   = st_r.en_sw | wd[RUN_ENABLE_BIT];
          st_nxt.rst_sw  = st_r.rst_sw | wd[RESET_ENABLE_BIT];
          st_nxt.prot_sw = st_r.prot_sw | wd[KICK_PROTECT_BIT];
          st_nxt.lock    = st_r.lock | wd[OSC_LOCK_BIT];
          if (!wd[TIMEOUT_FLAG_BIT]) begin
            st_nxt.tof = 1'b0;
          end
          if (wd[WARNING_FLAG_BIT]) begin
            st_nxt.wflag = 1'b0;
          end
        end else if (apb_i.paddr == RELOAD_CONSTANT_OFS) begin
          if (st_r.prot_a) begin
            st_nxt.tof = 1'b1;
          end else if (wd[23:0] < RELOAD_MIN) begin
            st_nxt.reload = RELOAD_MIN;
          end else begin
            st_nxt.reload = wd[23:0];
          end
        end else if (apb_i.paddr == KICK_SEQUENCE_OFS) begin
          if (wd[7:0] == KICK_FIRST) begin
            st_nxt.armed = 1'b1;
          end else if ((wd[7:0] == KICK_SECOND) && st_r.armed) begin
            feed = 1'b1;
          end
        end else if (apb_i.paddr == WARNING_COMPARE_OFS) begin
          st_nxt.warn = wd[9:0];
        end else if (apb_i.paddr == EARLY_KICK_LIMIT_OFS) begin
          st_nxt.win = wd[23:0];
        end
      end
    end

    // ==========================================================
    // Counting on count clock edges
    if (cc_rise) begin
      st_nxt.rb = st_r.cnt;
      if (st_r.ld_pend) begin
        if (st_r.ld_cnt == APPLY_EDGES - 2'h1) begin
          // Pending mode bits take effect only here
          st_nxt.ld_pend = 1'b0;
          st_nxt.cnt     = st_r.reload;
          st_nxt.pre     = 2'h0;
          st_nxt.en_a    = st_r.en_sw;
          st_nxt.rst_a   = st_r.rst_sw;
          st_nxt.prot_a  = st_r.prot_sw;
          st_nxt.running = st_r.en_sw;
        end else begin
          st_nxt.ld_cnt = st_r.ld_cnt + 2'h1;
        end
      end else if (st_r.running) begin
        if (wm) begin
          st_nxt.wflag = 1'b1;
        end
        if (st_r.cnt == 24'h00_0000) begin
          evt = 1'b1;
        end else begin
          st_nxt.pre = st_r.pre + 2'h1;
          if (st_r.pre == PRESCALE_LAST) begin
            st_nxt.cnt = st_r.cnt - 24'h00_0001;
          end
        end
      end
    end

    // Kick restarts the three-edge transfer
    if (feed) begin
      st_nxt.ld_pend = 1'b1;
      st_nxt.ld_cnt  = 2'h0;
      if (st_r.running && ((st_r.cnt > st_r.win) || (st_r.prot_a && !wm))) begin
        evt = 1'b1;
      end
    end

    // Events win over a simultaneous software clear
    st_nxt.err_pend = 1'b0;
    if (evt || kerr) begin
      st_nxt.tof = 1'b1;
      if (st_r.rst_a) begin
        st_nxt.err_pend = 1'b1;
      end
    end
    st_nxt.creset = st_r.err_pend;

    // Watchdog reset: all but the count-clock synchronizer back to reset, time-out flag kept for software
    if (st_r.creset) begin
      st_nxt        = WWT_RST;
      st_nxt.tof    = st_r.tof;
      st_nxt.cc_s1  = count_clk_i;
      st_nxt.cc_s2  = st_r.cc_s1;
      st_nxt.cc_s3  = st_r.cc_s2;
      st_nxt.cc_lvl = st_r.cc_lvl;
    end
  end

  // ==========================================================
  // Register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_r <= WWT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata_o     = st_r.prdata;
  assign pready_o     = st_r.pready;
  assign pslverr_o    = st_r.pslverr;
  assign warn_irq_o   = st_r.wflag;
  assign chip_reset_o = st_r.creset;
  assign osc_lock_o   = st_r.lock;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_run_enable_sticky: assert property (
    st_r.en_sw && !st_r.creset |=> st_r.en_sw)
    else $error("run enable cleared without reset");

  a_reset_en_sticky: assert property (
    st_r.rst_sw && !st_r.creset |=> st_r.rst_sw)
    else $error("reset enable cleared without reset");

  a_protect_sticky: assert property (
    st_r.prot_sw && !st_r.creset |=> st_r.prot_sw)
    else $error("protect cleared without reset");

  a_osc_lock_hold: assert property (
    osc_lock_o && !chip_reset_o |=> osc_lock_o)
    else $error("oscillator lock dropped");

  a_reload_floor: assert property (
    st_r.reload >= RELOAD_MIN)
    else $error("reload constant below minimum");

  a_kick_err_reset: assert property (
    kerr && st_r.rst_a && !st_r.err_pend && !st_r.creset |-> !chip_reset_o ##1 !chip_reset_o ##1 chip_reset_o)
    else $error("kick error reset not in second cycle");

  a_window_event: assert property (
    feed && st_r.running && (st_r.cnt > st_r.win) && !st_r.creset |=> st_r.tof)
    else $error("early kick did not set time-out flag");

  a_warn_one_edge: assert property (
    cc_rise && st_r.running && !st_r.ld_pend && wm && !st_r.creset |=> warn_irq_o)
    else $error("warning not raised after match");

  a_timeout_flag: assert property (
    cc_rise && st_r.running && !st_r.ld_pend && (st_r.cnt == 24'h00_0000) && !st_r.creset |=> st_r.tof)
    else $error("time-out did not set flag");

  a_stopped_hold: assert property (
    !st_r.running && !st_r.ld_pend && !st_r.creset |=> $stable(st_r.cnt))
    else $error("counter moved while stopped");

  a_mode_pending: assert property (
    $rose(st_r.en_a) |-> $past(st_r.ld_pend) && $past(cc_rise))
    else $error("mode applied without kick");

  // ==========================================================
  // Checks on bus side effects
  a_reload_locked: assert property (
    acc && apb_i.pwrite && (apb_i.paddr == RELOAD_CONSTANT_OFS) && st_r.prot_a && !st_r.creset
    |=> st_r.tof && $stable(st_r.reload))
    else $error("protected reload write not flagged");

  a_warn_zero_write: assert property (
    acc && apb_i.pwrite && (apb_i.paddr == MODE_CONTROL_OFS) && !apb_i.pwdata[WARNING_FLAG_BIT] && st_r.wflag
    && !st_r.creset |=> st_r.wflag)
    else $error("warning flag cleared by writing zero");

  a_tof_write_zero: assert property (
    acc && apb_i.pwrite && (apb_i.paddr == MODE_CONTROL_OFS) && !apb_i.pwdata[TIMEOUT_FLAG_BIT]
    && !evt && !kerr && !st_r.creset |=> !st_r.tof)
    else $error("time-out flag not cleared by writing zero");

  a_kick_err_flag: assert property (
    kerr && !st_r.creset |=> st_r.tof)
    else $error("kick error did not set time-out flag");

  a_feed_pending: assert property (
    feed && !st_r.creset |=> st_r.ld_pend && (st_r.ld_cnt == 2'h0))
    else $error("kick did not start the transfer");

  // No reset request may be scheduled unless the applied copy allows it
  a_reset_gate: assert property (
    !st_r.rst_a |=> !st_r.err_pend)
    else $error("reset scheduled without reset enable");

  a_idle_no_event: assert property (
    !st_r.running |=> !st_r.err_pend)
    else $error("event raised before first kick");

  // ==========================================================
  // Checks on counting
  a_apply_reload: assert property (
    cc_rise && st_r.ld_pend && (st_r.ld_cnt == APPLY_EDGES - 2'h1) && !st_r.creset
    |=> (st_r.cnt == $past(st_r.reload)) && (st_r.en_a == $past(st_r.en_sw)))
    else $error("reload not applied on third count edge");

  a_mode_held: assert property (
    !(cc_rise && st_r.ld_pend) && !st_r.creset
    |=> $stable(st_r.en_a) && $stable(st_r.rst_a) && $stable(st_r.prot_a))
    else $error("applied mode changed without kick");

  a_prescale_hold: assert property (
    cc_rise && st_r.running && !st_r.ld_pend && (st_r.pre != PRESCALE_LAST) && !st_r.creset
    |=> $stable(st_r.cnt))
    else $error("counter moved inside prescaler period");

  a_prescale_step: assert property (
    cc_rise && st_r.running && !st_r.ld_pend && (st_r.pre == PRESCALE_LAST) && (st_r.cnt != 24'h00_0000)
    && !st_r.creset |=> st_r.cnt == $past(st_r.cnt) - 24'h00_0001)
    else $error("counter did not step on fourth edge");

  a_zero_hold: assert property (
    st_r.running && !st_r.ld_pend && (st_r.cnt == 24'h00_0000) && !st_r.creset |=> st_r.cnt == 24'h00_0000)
    else $error("counter left zero without kick");

  a_warn_needs_match: assert property (
    !st_r.wflag && !(cc_rise && st_r.running && wm) |=> !st_r.wflag)
    else $error("warning flag set without match");

  a_readback_capture: assert property (
    cc_rise && !st_r.creset |=> st_r.rb == $past(st_r.cnt))
    else $error("readback not captured on count edge");

endmodule

// [common/wwt_pkg.sv]
// Package of register map, field layout, reset values and state types for the windowed watchdog
package wwt_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] MODE_CONTROL_OFS     = 8'h00;
  localparam logic [7:0] RELOAD_CONSTANT_OFS  = 8'h04;
  localparam logic [7:0] KICK_SEQUENCE_OFS    = 8'h08;
  localparam logic [7:0] COUNTER_READBACK_OFS = 8'h0c;
  localparam logic [7:0] WARNING_COMPARE_OFS  = 8'h14;
  localparam logic [7:0] EARLY_KICK_LIMIT_OFS = 8'h18;

  // ==========================================================
  // Mode control field positions
  localparam int RUN_ENABLE_BIT   = 0;
  localparam int RESET_ENABLE_BIT = 1;
  localparam int TIMEOUT_FLAG_BIT = 2;
  localparam int WARNING_FLAG_BIT = 3;
  localparam int KICK_PROTECT_BIT = 4;
  localparam int OSC_LOCK_BIT     = 5;

  // ==========================================================
  // Values and timing counts
  localparam logic [7:0]  KICK_FIRST    = 8'haa;
  localparam logic [7:0]  KICK_SECOND   = 8'h55;
  localparam logic [23:0] RELOAD_MIN    = 24'h00_00ff;
  localparam logic [23:0] WINDOW_RST    = 24'hff_ffff;
  localparam logic [9:0]  WARN_RST      = 10'h000;
  localparam int          WARN_BITS     = 10;
  localparam logic [1:0]  PRESCALE_LAST = 2'h3;
  localparam logic [1:0]  APPLY_EDGES   = 2'h3;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } wwt_apb_req_type;

  typedef struct packed {
    logic        cc_s1;
    logic        cc_s2;
    logic        cc_s3;
    logic        cc_lvl;
    logic [1:0]  pre;
    logic [23:0] cnt;
    logic [23:0] rb;
    logic [23:0] reload;
    logic [9:0]  warn;
    logic [23:0] win;
    logic        en_sw;
    logic        rst_sw;
    logic        prot_sw;
    logic        lock;
    logic        en_a;
    logic        rst_a;
    logic        prot_a;
    logic        running;
    logic        tof;
    logic        wflag;
    logic        armed;
    logic        ld_pend;
    logic [1:0]  ld_cnt;
    logic        err_pend;
    logic        creset;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } wwt_state_type;

  localparam wwt_state_type WWT_RST = '{cnt: RELOAD_MIN, rb: RELOAD_MIN, reload: RELOAD_MIN,
                                        warn: WARN_RST, win: WINDOW_RST, default: '0};

endpackage

// [verif/wwt_apb_host.sv]
// Processor model issuing APB register cycles and kick pairs to the watchdog
`timescale 1ns/1ps
module wwt_apb_host
  import wwt_pkg::*;
(
  // Clock
  input  wire logic            ref_clk_i,
  // APB towards the watchdog
  output wwt_apb_req_type      apb_o,
  input  wire logic [31:0]     prdata_i,
  input  wire logic            pready_i,
  input  wire logic            pslverr_i
);
  int stalls = 0;
  initial apb_o = '0;

  // ==========================================================
  // Bus cycle
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    #1;
    apb_o.psel   = 1'b1;
    apb_o.pwrite = wr;
    apb_o.paddr  = a;
    apb_o.pwdata = d;
    @(posedge ref_clk_i);
    #1;
    apb_o.penable = 1'b1;
    @(posedge ref_clk_i);
    while (pready_i !== 1'b1 && n < 16) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (pready_i !== 1'b1) stalls++;
    rd  = prdata_i;
    err = pslverr_i;
    #1;
    // Idle address and data lines show an inverted pattern, not the last value; pwrite keeps its last value
    apb_o.psel    = 1'b0;
    apb_o.penable = 1'b0;
    apb_o.paddr   = ~a;
    apb_o.pwdata  = ~d;
  endtask

  // ==========================================================
  // Kick pair, nothing in between
  task automatic kick;
    logic [31:0] r;
    logic        e;
    xfer(1'b1, KICK_SEQUENCE_OFS, 32'h0000_00aa, r, e);
    xfer(1'b1, KICK_SEQUENCE_OFS, 32'h0000_0055, r, e);
  endtask
endmodule

// [verif/tb_windowed_watchdog_timer.sv]
// Self-checking testbench of the windowed watchdog timer
`timescale 1ns/1ps
module tb_windowed_watchdog_timer;
  import wwt_pkg::*;
  logic            ref_clk, rst_n, count_clk;
  wwt_apb_req_type apb;
  logic [31:0]     prdata, rd, v;
  logic            pready, pslverr, warn_irq, chip_reset, osc_lock, err;
  int              fail_count = 0;
  int              checks_done = 0;
  int              resets = 0;
  int              n;

  wwt_top wwt_top_i (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .count_clk_i(count_clk), .apb_i(apb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .warn_irq_o(warn_irq),
    .chip_reset_o(chip_reset), .osc_lock_o(osc_lock));
  wwt_apb_host wwt_apb_host_i (.ref_clk_i(ref_clk), .apb_o(apb), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(pslverr));

  // ==========================================================
  // Clocks and monitors
  always #25 ref_clk = ~ref_clk;
  // Slow oscillator, unrelated phase, at least four bus clocks per half period
  always #230 count_clk = ~count_clk;
  // Sampled mid-cycle, so each one-cycle reset pulse counts once
  always @(negedge ref_clk) if (chip_reset === 1'b1) resets++;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] exp_reload(input logic [23:0] w);
    return {8'h00, (w < RELOAD_MIN) ? RELOAD_MIN : w};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic ticks(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wwt_apb_host_i.xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rd_at(input logic [7:0] a);
    wwt_apb_host_i.xfer(1'b0, a, 32'h0000_0000, rd, err);
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    ticks(2);
    rst_n = 1'b1;
  endtask
  task automatic conclude;
    fail_count = fail_count + wwt_apb_host_i.stalls;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #(60000 * 50);
    fail_count++;
    conclude();
  end

  // ==========================================================
  // Scenarios
  initial begin
    ref_clk = 1'b0;
    count_clk = 1'b0;
    rst_n = 1'b0;
    v = $urandom(32'h102e);
    do_reset();
    rd_at(MODE_CONTROL_OFS);     check(rd, 32'h0000_0000, "mode reset");
    rd_at(RELOAD_CONSTANT_OFS);  check(rd, 32'h0000_00ff, "reload reset");
    rd_at(COUNTER_READBACK_OFS); check(rd, 32'h0000_00ff, "readback reset");
    rd_at(WARNING_COMPARE_OFS);  check(rd, 32'h0000_0000, "warn reset");
    rd_at(EARLY_KICK_LIMIT_OFS); check(rd, 32'h00ff_ffff, "window reset");
    rd_at(8'h10);                check(32'(err), 32'h1, "hole error");
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'h0000_00fe : (i == 1) ? $urandom_range(254, 0) :
          (i == 2) ? 32'h0000_0100 : $urandom_range(32'h00ff_ffff, 32'h0000_0100);
      wr(RELOAD_CONSTANT_OFS, v);
      rd_at(RELOAD_CONSTANT_OFS);
      check(rd, exp_reload(v[23:0]), "reload store");
    end
    wr(MODE_CONTROL_OFS, 32'h0000_0021);
    wr(MODE_CONTROL_OFS, 32'h0000_0000);
    rd_at(MODE_CONTROL_OFS); check(rd, 32'h0000_0021, "sticky bits");
    check(32'(osc_lock), 32'h1, "osc lock");
    wr(KICK_SEQUENCE_OFS, 32'h0000_00aa);
    ticks(200);
    rd_at(MODE_CONTROL_OFS); check(rd, 32'h0000_0021, "early error ignored");
    rd_at(COUNTER_READBACK_OFS); check(rd, 32'h0000_00ff, "idle counter");
    // Plain time-out without reset enable
    wr(RELOAD_CONSTANT_OFS, 32'h0000_0000);
    wwt_apb_host_i.kick();
    ticks(800);
    rd_at(COUNTER_READBACK_OFS); check(32'(rd < 32'hff && rd > 32'h80), 32'h1, "counting");
    check(32'(warn_irq), 32'h0, "no early warning");
    n = 0;
    while (warn_irq !== 1'b1 && n < 12000) begin
      ticks(1);
      n++;
    end
    check(32'(n < 12000), 32'h1, "warning wait");
    rd_at(MODE_CONTROL_OFS); check(rd, 32'h0000_002d, "timeout flags");
    check(resets, 0, "no reset request");
    wwt_apb_host_i.kick();
    ticks(60);
    wr(MODE_CONTROL_OFS, 32'h0000_0008);
    rd_at(MODE_CONTROL_OFS); check(rd, 32'h0000_0021, "flags cleared");
    // Early kick with reset enabled, then watchdog reset
    do_reset();
    rd_at(MODE_CONTROL_OFS); check(rd, 32'h0000_0000, "external clears");
    wr(MODE_CONTROL_OFS, 32'h0000_0003);
    wr(EARLY_KICK_LIMIT_OFS, 32'h0000_0080);
    wwt_apb_host_i.kick();
    ticks(60);
    wwt_apb_host_i.kick();
    ticks(4);
    check(resets, 1, "early kick reset");
    rd_at(MODE_CONTROL_OFS); check(rd, 32'h0000_0004, "after wd reset");
    // Bad access inside a kick pair
    wr(MODE_CONTROL_OFS, 32'h0000_0003);
    wwt_apb_host_i.kick();
    ticks(60);
    wr(KICK_SEQUENCE_OFS, 32'h0000_00aa);
    rd_at(WARNING_COMPARE_OFS);
    check(32'(chip_reset), 32'h0, "reset too early");
    ticks(1);
    check(32'(chip_reset), 32'h1, "kick error reset");
    ticks(1);
    check(32'(chip_reset), 32'h0, "reset pulse");
    // Protect mode
    do_reset();
    wr(MODE_CONTROL_OFS, 32'h0000_0011);
    wwt_apb_host_i.kick();
    ticks(60);
    wr(RELOAD_CONSTANT_OFS, 32'h0000_0200);
    rd_at(MODE_CONTROL_OFS);    check(rd, 32'h0000_0015, "protect write flag");
    rd_at(RELOAD_CONSTANT_OFS); check(rd, 32'h0000_00ff, "reload kept");
    wr(MODE_CONTROL_OFS, 32'h0000_0010);
    rd_at(MODE_CONTROL_OFS);    check(rd, 32'h0000_0011, "tof write zero");
    wwt_apb_host_i.kick();
    ticks(2);
    rd_at(MODE_CONTROL_OFS);    check(rd, 32'h0000_0015, "protect kick error");
    // Nonzero compare: match holds from the reload value on
    wr(WARNING_COMPARE_OFS, 32'h0000_03ff);
    ticks(60);
    check(32'(warn_irq), 32'h1, "warning match");
    wr(MODE_CONTROL_OFS, 32'h0000_0010);
    wwt_apb_host_i.kick();
    ticks(2);
    rd_at(MODE_CONTROL_OFS);    check(rd, 32'h0000_0019, "protect kick allowed");
    rd_at(WARNING_COMPARE_OFS); check(rd, 32'h0000_03ff, "warn compare");
    check(resets, 2, "no reset in protect");
    conclude();
  end
endmodule
